// File: inc/acx_cfg.svh
// constants of the converter control block: register indexes, fields,
// reset values and clock divider terminal counts.
// assumes a 32-bit ahb-lite bus where byte address = 4 * register index.
//
// Functional notes
// - port config value n turns the lowest n port lines into analog inputs, and value seven turns all eight.
// - the channel select value picks which analog input drives the converter.
// - result bits 9..2 fill the high byte and bits 1..0 sit in bits 7..6 of the low byte.
// - clock select 01 runs the converter at the system clock divided by eight.
// - a rising start edge resets the converter and sets the pending flag, the falling edge starts conversion.
// - the pending flag clears when a conversion finishes and the result bytes are valid.
// - a port config of zero powers the converter off and needs no start pulse.
`ifndef ACX_CFG_SVH
`define ACX_CFG_SVH

// register indexes
`define ACX_IDX_RES_LO    8'h24
`define ACX_IDX_RES_HI    8'h25
`define ACX_IDX_CTRL      8'h26
`define ACX_IDX_CLKSEL    8'h27
`define ACX_IDX_IRQ_STS   8'h28
`define ACX_IDX_IRQ_MSK   8'h29

// control register fields
`define ACX_CTRL_CHAN_LSB 0
`define ACX_CTRL_PCFG_LSB 3
`define ACX_CTRL_EOC_BIT  6
`define ACX_CTRL_STRT_BIT 7
`define ACX_CTRL_RST      8'h40

// clock select register fields
`define ACX_CLKSEL_TEST   7
`define ACX_CLKSEL_RST    8'h00
`define ACX_CLK_DIV2      2'h0
`define ACX_CLK_DIV8      2'h1
`define ACX_CLK_DIV32     2'h2

// divider terminal counts (divide ratio minus one)
`define ACX_TERM_DIV2     5'h01
`define ACX_TERM_DIV8     5'h07
`define ACX_TERM_DIV32    5'h1f

// interrupt bits
`define ACX_IRQ_DONE      0
`define ACX_IRQ_RESTART   1
`define ACX_IRQ_RST       2'h0

// result width and low byte pad
`define ACX_RES_BITS      10
`define ACX_LO_PAD        6'h00

`endif

// File: inc/acx_pkg.sv
// types of the converter control block.
// assumes acx_cfg.svh holds every number.
package acx_pkg;

   // successive approximation sequencer states
   typedef enum logic [1:0]
   {
      ACX_SAR_IDLE,
      ACX_SAR_SAMPLE,
      ACX_SAR_TRIAL
   } acx_sar_state_t;

endpackage

// File: rtl/acx_ctrl.sv
// ahb-lite register slave and control of the eight-channel converter.
// assumes a single ahb-lite master, the analog mux, sample switch and
// dac outside, and a comparator output arriving asynchronously.
`timescale 1ns/1ps
`include "acx_cfg.svh"
module acx_ctrl
   import acx_pkg::*;
#(
   parameter int RES_W = `ACX_RES_BITS
)
(
   input  wire logic              hclk,
   input  wire logic              hresetn,
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output logic                   hreadyout,
   output logic                   hresp,
   output logic [31:0]            hrdata,
   input  wire logic              cmp_in,
   output logic [7:0]             analog_en,
   output logic [2:0]             chan_mux,
   output logic                   conv_power,
   output logic                   conv_sample,
   output logic [RES_W-1:0]       dac_code,
   output logic                   irq
);
   // control reset word, so the flag's reset value comes from its bit
   localparam logic [7:0] CTRL_RST = `ACX_CTRL_RST;

   // bus state
   logic              rd_pend_q, rd_pend_d;
   logic              wr_pend_q, wr_pend_d;
   logic [7:0]        aidx_q, aidx_d;
   logic              ahit_q, ahit_d;
   logic              ready_q, ready_d;
   logic [31:0]       rdata_q, rdata_d;
   // register state
   logic [2:0]        chan_q, chan_d;
   logic [2:0]        pcfg_q, pcfg_d;
   logic              pend_q, pend_d;
   logic              start_q, start_d;
   logic              start_old_q;
   logic [7:0]        clksel_q, clksel_d;
   logic [1:0]        sts_q, sts_d;
   logic [1:0]        msk_q, msk_d;
   logic              irq_q;
   logic [7:0]        ana_q, ana_d;
   // converter clock and comparator
   logic [4:0]        div_q, div_d;
   logic [4:0]        term;
   logic              cmp_s1_q, cmp_s2_q;
   // converter control
   logic              accept, wr_now, start_rise, start_fall;
   logic              go, abort, step_en, powered;
   logic              sar_done;
   logic [RES_W-1:0]  result;
   logic [7:0]        ctrl_rd;

   acx_sar #(.WIDTH(RES_W)) u_sar
   (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .step_en  (step_en),
      .go       (go),
      .abort    (abort),
      .cmp_hi   (cmp_s2_q),
      .dac_q    (dac_code),
      .sample_q (conv_sample),
      .done_q   (sar_done),
      .result_q (result)
   );

   // start edges and converter hold; zero config means powered off
   assign powered    = (pcfg_q != 3'h0);
   assign start_rise = start_q & ~start_old_q;
   assign start_fall = ~start_q & start_old_q;
   assign go         = start_fall & powered;
   assign abort      = start_q | ~powered;
   assign accept     = hsel & hready & htrans[1];
   assign wr_now     = wr_pend_q & ahit_q;
   assign ctrl_rd    = {start_q, pend_q, pcfg_q, chan_q};

   // divider terminal from the clock select field
   always_comb
   begin
      case (clksel_q[1:0])
         `ACX_CLK_DIV2:  term = `ACX_TERM_DIV2;
         `ACX_CLK_DIV8:  term = `ACX_TERM_DIV8;
         default:        term = `ACX_TERM_DIV32;  // 11 taken as /32
      endcase
   end
   assign step_en = (div_q == term);

   // bus next state: writes take no wait, reads take one so that a read
   // right after a write sees the written value
   always_comb
   begin
      rd_pend_d = 1'b0;
      wr_pend_d = 1'b0;
      aidx_d    = aidx_q;
      ahit_d    = ahit_q;
      ready_d   = 1'b1;
      rdata_d   = rdata_q;
      if (rd_pend_q && !ready_q)
      begin
         rdata_d = 32'h0000_0000;
         if (ahit_q)
         begin
            case (aidx_q)
               `ACX_IDX_RES_LO:  rdata_d[7:0] = {result[1:0], `ACX_LO_PAD};
               `ACX_IDX_RES_HI:  rdata_d[7:0] = result[RES_W-1:2];
               `ACX_IDX_CTRL:    rdata_d[7:0] = ctrl_rd;
               `ACX_IDX_CLKSEL:
               begin
                  rdata_d[7:0] = {clksel_q[7], 5'h00, clksel_q[1:0]};
               end
               `ACX_IDX_IRQ_STS: rdata_d[1:0] = sts_q;
               `ACX_IDX_IRQ_MSK: rdata_d[1:0] = msk_q;
               default:          rdata_d      = 32'h0000_0000;
            endcase
         end
      end
      else if (accept)
      begin
         aidx_d    = haddr[9:2];
         ahit_d    = (haddr[31:10] == 22'h00_0000) && (haddr[1:0] == 2'h0);
         rd_pend_d = ~hwrite;
         wr_pend_d = hwrite;
         ready_d   = hwrite;
      end
   end

   // register next state
   always_comb
   begin
      chan_d   = chan_q;
      pcfg_d   = pcfg_q;
      start_d  = start_q;
      clksel_d = clksel_q;
      msk_d    = msk_q;
      pend_d   = pend_q;
      sts_d    = sts_q;
      if (wr_now && aidx_q == `ACX_IDX_CTRL)
      begin
         // config change leaves the flag stale until a start pulse
         chan_d  = hwdata[`ACX_CTRL_CHAN_LSB +: 3];
         pcfg_d  = hwdata[`ACX_CTRL_PCFG_LSB +: 3];
         start_d = hwdata[`ACX_CTRL_STRT_BIT];
      end
      if (wr_now && aidx_q == `ACX_IDX_CLKSEL)
         clksel_d = {hwdata[`ACX_CLKSEL_TEST], 5'h00, hwdata[1:0]};
      if (wr_now && aidx_q == `ACX_IDX_IRQ_MSK)
         msk_d = hwdata[1:0];
      if (wr_now && aidx_q == `ACX_IDX_IRQ_STS)
         sts_d = sts_q & ~hwdata[1:0];
      // events set after the clear so a same-cycle event is kept
      if (sar_done)
         sts_d[`ACX_IRQ_DONE] = 1'b1;
      if (start_rise)
         sts_d[`ACX_IRQ_RESTART] = 1'b1;
      // flag polled by software until zero
      if (start_rise)
         pend_d = 1'b1;
      else if (sar_done)
         pend_d = 1'b0;
   end

   // lines below the config value go analog, seven means all eight
   always_comb
   begin
      for (int i = 0; i < 8; i++)
         ana_d[i] = (pcfg_d == 3'h7) || (i < int'(pcfg_d));
   end

   // converter clock enable; stalls while the converter is held
   always_comb
   begin
      if (abort || step_en)
         div_d = 5'h00;
      else
         div_d = div_q + 5'h01;
   end

   // bus registers
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         rd_pend_q <= 1'b0;
         wr_pend_q <= 1'b0;
         aidx_q    <= 8'h00;
         ahit_q    <= 1'b0;
         ready_q   <= 1'b1;
         rdata_q   <= 32'h0000_0000;
      end
      else
      begin
         rd_pend_q <= rd_pend_d;
         wr_pend_q <= wr_pend_d;
         aidx_q    <= aidx_d;
         ahit_q    <= ahit_d;
         ready_q   <= ready_d;
         rdata_q   <= rdata_d;
      end
   end

   // control registers and outputs
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         chan_q      <= 3'h0;
         pcfg_q      <= 3'h0;
         start_q     <= 1'b0;
         start_old_q <= 1'b0;
         pend_q      <= CTRL_RST[`ACX_CTRL_EOC_BIT];
         clksel_q    <= `ACX_CLKSEL_RST;
         sts_q       <= `ACX_IRQ_RST;
         msk_q       <= `ACX_IRQ_RST;
         irq_q       <= 1'b0;
         ana_q       <= 8'h00;
         div_q       <= 5'h00;
         cmp_s1_q    <= 1'b0;
         cmp_s2_q    <= 1'b0;
      end
      else
      begin
         chan_q      <= chan_d;
         pcfg_q      <= pcfg_d;
         start_q     <= start_d;
         start_old_q <= start_q;
         pend_q      <= pend_d;
         clksel_q    <= clksel_d;
         sts_q       <= sts_d;
         msk_q       <= msk_d;
         irq_q       <= |(sts_d & msk_d);
         ana_q       <= ana_d;
         div_q       <= div_d;
         cmp_s1_q    <= cmp_in;
         cmp_s2_q    <= cmp_s1_q;
      end
   end

   // outputs straight from flops, hresp tied to okay; the mux follows the select
   assign hreadyout  = ready_q;
   assign hresp      = 1'b0;   // always okay
   assign hrdata     = rdata_q;
   assign analog_en  = ana_q;
   assign chan_mux   = chan_q;
   assign conv_power = ~ana_q[0] ? 1'b0 : 1'b1;
   assign irq        = irq_q;
endmodule // acx_ctrl

// File: rtl/acx_sar.sv
// successive approximation sequencer of the converter.
// assumes step_en is a one-cycle pulse of the converter clock and cmp_hi
// is already synchronised to hclk.
`timescale 1ns/1ps
module acx_sar
   import acx_pkg::*;
#(
   parameter int WIDTH = 10
)
(
   input  wire logic             hclk,
   input  wire logic             hresetn,
   input  wire logic             step_en,
   input  wire logic             go,
   input  wire logic             abort,
   input  wire logic             cmp_hi,
   output logic [WIDTH-1:0]      dac_q,
   output logic                  sample_q,
   output logic                  done_q,
   output logic [WIDTH-1:0]      result_q
);
   localparam int IW = $clog2(WIDTH);

   acx_sar_state_t    state_q;
   acx_sar_state_t    state_d;
   logic [IW-1:0]     idx_q;
   logic [IW-1:0]     idx_d;
   logic [WIDTH-1:0]  dac_d;
   logic [WIDTH-1:0]  result_d;
   logic [WIDTH-1:0]  trial;
   logic              sample_d;
   logic              done_d;

   // next state: one sample step, then one trial bit per step, msb first
   always_comb
   begin
      state_d  = state_q;
      idx_d    = idx_q;
      dac_d    = dac_q;
      result_d = result_q;
      sample_d = sample_q;
      done_d   = 1'b0;
      trial    = dac_q;
      if (abort)
      begin
         state_d  = ACX_SAR_IDLE;  // converter held in reset
         dac_d    = '0;
         sample_d = 1'b0;
      end
      else
      begin
         case (state_q)
            ACX_SAR_IDLE:
            begin
               if (go)
               begin
                  state_d  = ACX_SAR_SAMPLE;
                  sample_d = 1'b1;
                  dac_d    = '0;
               end
            end
            ACX_SAR_SAMPLE:
            begin
               if (step_en)
               begin
                  sample_d            = 1'b0;
                  idx_d               = IW'(WIDTH - 1);
                  dac_d               = '0;
                  dac_d[WIDTH-1]      = 1'b1;
                  state_d             = ACX_SAR_TRIAL;
               end
            end
            ACX_SAR_TRIAL:
            begin
               if (step_en)
               begin
                  // keep the trial bit only while the input is at or above it
                  if (!cmp_hi)
                     trial[idx_q] = 1'b0;
                  if (idx_q == '0)
                  begin
                     result_d = trial;   // held until next finish
                     done_d   = 1'b1;
                     state_d  = ACX_SAR_IDLE;
                  end
                  else
                  begin
                     idx_d               = idx_q - 1'b1;
                     trial[idx_q - 1'b1] = 1'b1;
                  end
                  dac_d = trial;
               end
            end
            default:
            begin
               state_d = ACX_SAR_IDLE;
            end
         endcase
      end
   end

   // sequencer registers
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         state_q  <= ACX_SAR_IDLE;
         idx_q    <= '0;
         dac_q    <= '0;
         result_q <= '0;
         sample_q <= 1'b0;
         done_q   <= 1'b0;
      end
      else
      begin
         state_q  <= state_d;
         idx_q    <= idx_d;
         dac_q    <= dac_d;
         result_q <= result_d;
         sample_q <= sample_d;
         done_q   <= done_d;
      end
   end
endmodule // acx_sar

// File: testbench/acx_ctrl_monitor.sv
// port checker of the converter control block.
// assumes one ahb-lite master with hready tied to hreadyout.
`timescale 1ns/1ps
`include "acx_cfg.svh"
module acx_chk
(
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [31:0] hrdata,
   input wire logic [7:0]  analog_en,
   input wire logic [2:0]  chan_mux,
   input wire logic        conv_power,
   input wire logic        conv_sample
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // transfer taken, and a read of the low result byte
   wire logic acc = hsel && hready && htrans[1];
   wire logic rdlo = acc && !hwrite
      && haddr == {22'h0, `ACX_IDX_RES_LO, 2'b00};
   // only thermometer shapes: seven lines analog is never a legal map
   a_analog_thermo: assert property (analog_en inside
      {8'h00, 8'h01, 8'h03, 8'h07, 8'h0f, 8'h1f, 8'h3f, 8'hff})
      else $error("analog map not thermometer");
   a_power_cfg: assert property (conv_power == (analog_en != 8'h00))
      else $error("power does not follow config");
   a_sample_power: assert property (conv_sample |-> conv_power)
      else $error("sampling while powered off");
   a_cfg_by_write: assert property ($changed({analog_en, chan_mux})
      |-> $past(acc && hwrite, 2))
      else $error("mux changed without a write");
   a_read_wait: assert property (acc && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
   a_write_nowait: assert property (acc && hwrite |=> hreadyout)
      else $error("write stalled");
   a_okay_resp: assert property (hresp == 1'b0)
      else $error("response not okay");
   // bits 7..6 carry result bits, only the pad below and the top are zero
   a_low_pad: assert property (rdlo |=> ##1 (hrdata[5:0] == 6'h00
      && hrdata[31:8] == 24'h0))
      else $error("low result pad not zero");
   c_sample: cover property (conv_sample);
   c_all_analog: cover property (analog_en == 8'hff);
   c_read: cover property (acc && !hwrite);
endmodule // acx_chk

bind acx_ctrl acx_chk u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
   .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
   .analog_en(analog_en), .chan_mux(chan_mux), .conv_power(conv_power),
   .conv_sample(conv_sample));

// File: testbench/tb.sv
// self-checking bench of the converter control block.
// assumes the control block alone on the bus, hready = hreadyout.
`timescale 1ns/1ps
`include "acx_cfg.svh"
module tb;
   logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hreadyout, hresp, cmp_in = 0, conv_power, conv_sample, irq;
   logic [31:0] hrdata, rv;
   logic [7:0]  analog_en;
   logic [2:0]  chan_mux;
   logic [9:0]  dac_code, target = 10'h0;
   int          mismatches = 0, n_compared = 0, cycles = 0;

   acx_ctrl DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .cmp_in(cmp_in),
      .analog_en(analog_en), .chan_mux(chan_mux), .conv_power(conv_power),
      .conv_sample(conv_sample), .dac_code(dac_code), .irq(irq));

   // 20 mhz clock; a hung wait ends the run as a failure
   always #25 hclk = ~hclk;
   always @(posedge hclk)
   begin
      cycles++;
      if (cycles >= 20000)
      begin
         mismatches++;
         results();
      end
   end
   // comparator stand-in: input at or above the trial code
   always @(posedge hclk)
      cmp_in <= (target >= dac_code);

   task automatic chk(input string nm, input [31:0] e, input [31:0] g);
      n_compared++;
      if (g !== e)
      begin
         mismatches++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask

   // one ahb-lite single transfer; entered just after a rising edge
   task automatic xfer(input [7:0] idx, input w, input [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {22'h0, idx, 2'b00};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rv = hrdata;
   endtask

   task automatic rdchk(input string nm, input [7:0] idx, input [31:0] e);
      xfer(idx, 1'b0, 32'h0);
      chk(nm, e, rv);
   endtask

   // reset values of every register but the low result byte, an unmapped read, a result write
   task automatic t_reset;
      rdchk("ctrl", `ACX_IDX_CTRL, 32'h40);
      rdchk("clksel", `ACX_IDX_CLKSEL, 32'h0);
      rdchk("status", `ACX_IDX_IRQ_STS, 32'h0);
      rdchk("mask", `ACX_IDX_IRQ_MSK, 32'h0);
      xfer(`ACX_IDX_RES_HI, 1'b1, 32'hff);
      rdchk("res_hi", `ACX_IDX_RES_HI, 32'h0);
      rdchk("unmapped", 8'h3f, 32'h0);
   endtask

   // every port config and channel value
   task automatic t_port_cfg;
      for (int n = 0; n < 8; n++)
      begin
         xfer(`ACX_IDX_CTRL, 1'b1, 32'(n * 9));
         @(posedge hclk); // outputs already follow the write at the edge it lands on
         chk("analog_en", (n == 7) ? 8'hff : (8'h1 << n) - 8'h1,
            analog_en);
         chk("chan_mux", n, chan_mux);
         chk("power", n != 0, conv_power);
         // every config change is followed by an init pulse
         xfer(`ACX_IDX_CTRL, 1'b1, 32'(n * 9 + 128));
         xfer(`ACX_IDX_CTRL, 1'b1, 32'(n * 9));
      end
   endtask

   // start pulse, poll, then read high and low bytes
   task automatic t_convert(input [1:0] sel, input int div, input [9:0] t);
      int n;
      target <= t;
      xfer(`ACX_IDX_CLKSEL, 1'b1, 32'(sel));
      xfer(`ACX_IDX_IRQ_MSK, 1'b1, 32'h1);
      xfer(`ACX_IDX_CTRL, 1'b1, 32'h3b); // config, then start at once
      xfer(`ACX_IDX_CTRL, 1'b1, 32'hbb);
      // drop a done left by earlier pulses; converter is held now
      xfer(`ACX_IDX_IRQ_STS, 1'b1, 32'h1);
      rdchk("pending set", `ACX_IDX_CTRL, 32'hfb);
      chk("irq masked", 1'b0, irq);
      xfer(`ACX_IDX_CTRL, 1'b1, 32'h3b); // falling edge starts
      // poll the pending flag; each read costs three edges
      n = 0;
      do
      begin
         xfer(`ACX_IDX_CTRL, 1'b0, 32'h0);
         n = n + 3;
      end
      while (rv[`ACX_CTRL_EOC_BIT] !== 1'b0 && n < 2000);
      chk("conv time ok", 1, n >= 10 * div && n <= 12 * div + 8);
      rdchk("done", `ACX_IDX_CTRL, 32'h3b); // polled flag clear
      chk("irq done", 1'b1, irq);
      chk("dac final", t, dac_code);
      rdchk("res_hi", `ACX_IDX_RES_HI, 32'(t[9:2]));
      rdchk("res_lo", `ACX_IDX_RES_LO, {24'h0, t[1:0], 6'h0});
      rdchk("status", `ACX_IDX_IRQ_STS, 32'h3);
      xfer(`ACX_IDX_IRQ_STS, 1'b1, 32'h3);
      @(posedge hclk); // irq follows the clear at the landing edge
      chk("irq clear", 1'b0, irq);
      rdchk("res_lo kept", `ACX_IDX_RES_LO, {24'h0, t[1:0], 6'h0});
   endtask

   // converter off: a start pulse leaves the flag set and results alone
   task automatic t_off(input [9:0] t);
      xfer(`ACX_IDX_CTRL, 1'b1, 32'h80);
      xfer(`ACX_IDX_CTRL, 1'b1, 32'h00);
      repeat (400) @(posedge hclk);
      rdchk("off pending", `ACX_IDX_CTRL, 32'h40);
      rdchk("off res_hi", `ACX_IDX_RES_HI, 32'(t[9:2]));
   endtask

   task automatic results;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   initial
   begin
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_reset();
      t_port_cfg();
      t_convert(`ACX_CLK_DIV8, 8, 10'h2c5);
      t_convert(`ACX_CLK_DIV32, 32, 10'h13a);
      t_off(10'h13a);
      results();
   end
endmodule // tb
